//--- shared/masc_map.vh
// Register map constants for the converter sequence step configuration bank
`ifndef MASC_MAP_VH
`define MASC_MAP_VH

// ----------------------------------------------------------------
// Register indices and byte addresses (byte address = 4 * index)
// ----------------------------------------------------------------
`define MASC_STEP11_IDX      8'h9B
`define MASC_STEP12_IDX      8'h9C
`define MASC_STEP11_ADDR     12'h26C
`define MASC_STEP12_ADDR     12'h270

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MASC_STEP11_RESET    16'h000B
`define MASC_STEP12_RESET    16'h000C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MASC_EN_BIT          15
`define MASC_GAIN_HI         14
`define MASC_GAIN_LO         13
`define MASC_NEG_BIT         4
`define MASC_POS_HI          3
`define MASC_POS_LO          0
`define MASC_WR_MASK         16'hE01F

// ----------------------------------------------------------------
// Positive input codes for internal sources
// ----------------------------------------------------------------
`define MASC_POS_TEMP        4'h8
`define MASC_POS_SHORT       4'h9
`define MASC_POS_DAC         4'hA
`define MASC_POS_IO_SUPPLY   4'hC
`define MASC_POS_ANALOG_POWER_RAIL        4'hE
`define MASC_POS_DIGITAL_POWER_RAIL        4'hF

// ----------------------------------------------------------------
// Negative input route encodings
// ----------------------------------------------------------------
`define MASC_NEG_GROUND      2'h0
`define MASC_NEG_EXT7        2'h1
`define MASC_NEG_AUTO        2'h2

`endif

//--- logic/masc_step_config.v
// Sequence step 11/12 configuration registers with APB access and decode
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`include "masc_map.vh"

// ----------------------------------------------------------------
// Per-step decoder
// ----------------------------------------------------------------
module masc_step_decode (
  input  wire        clk,          // System clock
  input  wire        rst,          // Synchronous reset
  input  wire [15:0] cfg,          // Stored step configuration
  output reg         enable,       // Step enabled
  output reg  [2:0]  gain_factor,  // Converter gain 1, 2 or 4
  output reg  [1:0]  neg_route,    // Ground, input seven or automatic
  output reg  [7:0]  ext_pos_sel,  // One-hot external positive input
  output reg  [5:0]  int_src_sel,  // One-hot internal source
  output reg         src_undefined // Code selects no defined source
);

  wire [3:0] pos = cfg[`MASC_POS_HI:`MASC_POS_LO];
  wire [1:0] gcode = cfg[`MASC_GAIN_HI:`MASC_GAIN_LO];
  reg  [5:0] int_next;

  always @* begin
    int_next = 6'h00;
    case (pos)
      `MASC_POS_TEMP:      int_next = 6'h01;
      `MASC_POS_SHORT:     int_next = 6'h02;
      `MASC_POS_DAC:       int_next = 6'h04;
      `MASC_POS_IO_SUPPLY: int_next = 6'h08;
      `MASC_POS_ANALOG_POWER_RAIL:      int_next = 6'h10;
      `MASC_POS_DIGITAL_POWER_RAIL:      int_next = 6'h20;
      default:             int_next = 6'h00;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      enable        <= 1'b0;
      gain_factor   <= 3'h1;
      neg_route     <= `MASC_NEG_GROUND;
      ext_pos_sel   <= 8'h00;
      int_src_sel   <= 6'h00;
      src_undefined <= 1'b0;
    end else begin
      enable <= cfg[`MASC_EN_BIT];
      case (gcode)
        2'h0:    gain_factor <= 3'h1;
        2'h1:    gain_factor <= 3'h2;
        default: gain_factor <= 3'h4;
      endcase
      // Internal sources override the negative select bit
      if (pos[3])
        neg_route <= `MASC_NEG_AUTO;
      else if (cfg[`MASC_NEG_BIT])
        neg_route <= `MASC_NEG_EXT7;
      else
        neg_route <= `MASC_NEG_GROUND;
      ext_pos_sel   <= pos[3] ? 8'h00 : (8'h01 << pos[2:0]);
      int_src_sel   <= int_next;
      // Unassigned codes route nothing and are flagged
      src_undefined <= pos[3] && (int_next == 6'h00);
    end
  end

endmodule // masc_step_decode

module masc_step_config (
  input  wire        clk,                  // System clock, 100 MHz
  input  wire        rst,                  // Synchronous reset
  input  wire        psel,                 // APB select
  input  wire        penable,              // APB enable
  input  wire        pwrite,               // APB direction
  input  wire [11:0] paddr,                // APB byte address
  input  wire [31:0] pwdata,               // APB write data
  input  wire [3:0]  pstrb,                // APB byte strobes
  output wire        pready,               // APB ready, no wait states
  output wire        pslverr,              // APB error, unmapped address
  output reg  [31:0] prdata,               // APB read data
  output wire        step11_enable,        // Step 11 enabled
  output wire [1:0]  step11_gain_sel,      // Step 11 raw gain code
  output wire        step11_neg_input_sel, // Step 11 raw negative select
  output wire [3:0]  step11_pos_input_sel, // Step 11 raw positive code
  output wire [2:0]  step11_gain_factor,   // Step 11 gain 1, 2 or 4
  output wire [1:0]  step11_neg_route,     // Step 11 negative route
  output wire [7:0]  step11_ext_pos_sel,   // Step 11 one-hot external
  output wire [5:0]  step11_int_src_sel,   // Step 11 one-hot internal
  output wire        step11_src_undefined, // Step 11 undefined code
  output wire        step12_enable,        // Step 12 enabled
  output wire [1:0]  step12_gain_sel,      // Step 12 raw gain code
  output wire        step12_neg_input_sel, // Step 12 raw negative select
  output wire [3:0]  step12_pos_input_sel, // Step 12 raw positive code
  output wire [2:0]  step12_gain_factor,   // Step 12 gain 1, 2 or 4
  output wire [1:0]  step12_neg_route,     // Step 12 negative route
  output wire [7:0]  step12_ext_pos_sel,   // Step 12 one-hot external
  output wire [5:0]  step12_int_src_sel,   // Step 12 one-hot internal
  output wire        step12_src_undefined  // Step 12 undefined code
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  reg  [15:0] step11_reg;
  reg  [15:0] step12_reg;
  wire        hit11  = (paddr == `MASC_STEP11_ADDR);
  wire        hit12  = (paddr == `MASC_STEP12_ADDR);
  wire        access = psel && penable;
  wire        wr_en  = access && pwrite;
  wire [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  // Reserved bits never take write data
  wire [15:0] wmask  = lane_mask & `MASC_WR_MASK;

  assign pready  = 1'b1;
  assign pslverr = access && !(hit11 || hit12);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      step11_reg <= `MASC_STEP11_RESET;
      step12_reg <= `MASC_STEP12_RESET;
    end else if (wr_en) begin
      if (hit11)
        step11_reg <= (step11_reg & ~wmask) | (pwdata[15:0] & wmask);
      if (hit12)
        step12_reg <= (step12_reg & ~wmask) | (pwdata[15:0] & wmask);
    end
  end

  // ----------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------
  // No write can land between setup and access, so data stays current
  always @(posedge clk) begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable) begin
      if (paddr == `MASC_STEP11_ADDR)
        prdata <= {16'h0000, step11_reg & `MASC_WR_MASK};
      else if (paddr == `MASC_STEP12_ADDR)
        prdata <= {16'h0000, step12_reg & `MASC_WR_MASK};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Raw field outputs and decoders
  // ----------------------------------------------------------------
  assign step11_enable        = step11_reg[`MASC_EN_BIT];
  assign step11_gain_sel      = step11_reg[`MASC_GAIN_HI:`MASC_GAIN_LO];
  assign step11_neg_input_sel = step11_reg[`MASC_NEG_BIT];
  assign step11_pos_input_sel = step11_reg[`MASC_POS_HI:`MASC_POS_LO];
  assign step12_enable        = step12_reg[`MASC_EN_BIT];
  assign step12_gain_sel      = step12_reg[`MASC_GAIN_HI:`MASC_GAIN_LO];
  assign step12_neg_input_sel = step12_reg[`MASC_NEG_BIT];
  assign step12_pos_input_sel = step12_reg[`MASC_POS_HI:`MASC_POS_LO];

  masc_step_decode u_dec11 (
    .clk           (clk),
    .rst           (rst),
    .cfg           (step11_reg),
    .enable        (),
    .gain_factor   (step11_gain_factor),
    .neg_route     (step11_neg_route),
    .ext_pos_sel   (step11_ext_pos_sel),
    .int_src_sel   (step11_int_src_sel),
    .src_undefined (step11_src_undefined)
  );

  masc_step_decode u_dec12 (
    .clk           (clk),
    .rst           (rst),
    .cfg           (step12_reg),
    .enable        (),
    .gain_factor   (step12_gain_factor),
    .neg_route     (step12_neg_route),
    .ext_pos_sel   (step12_ext_pos_sel),
    .int_src_sel   (step12_int_src_sel),
    .src_undefined (step12_src_undefined)
  );

endmodule // masc_step_config

//--- testbench/masc_step_config_properties.sv
// Concurrent checks on the step configuration bank ports
`timescale 1ns/100ps
`include "masc_map.vh"
module masc_step_config_props (
  input wire        clk,                  // Clock
  input wire        rst,                  // Reset
  input wire        psel,                 // APB select
  input wire        penable,              // APB enable
  input wire        pwrite,               // APB direction
  input wire [11:0] paddr,                // APB address
  input wire [31:0] pwdata,               // APB write data
  input wire [3:0]  pstrb,                // APB strobes
  input wire [31:0] prdata,               // APB read data
  input wire        step11_enable,        // Step 11 enable
  input wire [1:0]  step11_gain_sel,      // Step 11 gain code
  input wire [2:0]  step11_gain_factor,   // Step 11 gain
  input wire        step11_neg_input_sel, // Step 11 negative select
  input wire [3:0]  step11_pos_input_sel, // Step 11 positive code
  input wire [1:0]  step11_neg_route,     // Step 11 negative route
  input wire [7:0]  step11_ext_pos_sel,   // Step 11 external one-hot
  input wire        step11_src_undefined, // Step 11 undefined code
  input wire [3:0]  step12_pos_input_sel, // Step 12 positive code
  input wire [5:0]  step12_int_src_sel    // Step 12 internal one-hot
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr11_hi;
    psel && penable && pwrite && paddr == `MASC_STEP11_ADDR && pstrb[1];
  endsequence
  property p_en11; s_wr11_hi |=> step11_enable == $past(pwdata[15]);
  endproperty
  a_en11: assert property (p_en11)
    else $error("step 11 enable not written");
  property p_gain; !rst |=> step11_gain_factor ==
    ($past(step11_gain_sel) == 2'h0 ? 3'h1 :
     $past(step11_gain_sel) == 2'h1 ? 3'h2 : 3'h4); endproperty
  a_gain: assert property (p_gain)
    else $error("gain factor wrong");
  property p_resv; prdata[31:16] == 16'h0000 && prdata[12:5] == 8'h00;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved read bits not zero");
  // Decoders load decoded values on the first edge after release
  property p_route; !rst |=> step11_neg_route ==
    ($past(step11_pos_input_sel[3]) ? 2'h2 :
     {1'b0, $past(step11_neg_input_sel)}); endproperty
  a_route: assert property (p_route)
    else $error("negative route wrong");
  property p_ext; !rst |=> step11_ext_pos_sel ==
    ($past(step11_pos_input_sel[3]) ? 8'h00 :
     8'h01 << $past(step11_pos_input_sel[2:0])); endproperty
  a_ext: assert property (p_ext)
    else $error("external input select wrong");
  property p_int12; !rst && step12_pos_input_sel == 4'hC |=>
    step12_int_src_sel == 6'h08; endproperty
  a_int12: assert property (p_int12)
    else $error("io supply source not selected");
  property p_undef; !rst |=> step11_src_undefined ==
    ($past(step11_pos_input_sel) inside {4'hB, 4'hD}); endproperty
  a_undef: assert property (p_undef)
    else $error("undefined code flag wrong");
  property p_rstv; $past(rst) |-> step11_pos_input_sel == 4'hB &&
    step12_pos_input_sel == 4'hC; endproperty
  a_rstv: assert property (p_rstv)
    else $error("positive code reset value wrong");
endmodule // masc_step_config_props
bind masc_step_config masc_step_config_props u_props (.clk, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .step11_enable,
  .step11_gain_sel, .step11_gain_factor, .step11_neg_input_sel,
  .step11_pos_input_sel, .step11_neg_route, .step11_ext_pos_sel,
  .step11_src_undefined, .step12_pos_input_sel, .step12_int_src_sel);

//--- testbench/tb_top.sv
// Self-checking bench for the step configuration bank
`timescale 1ns/100ps
`include "masc_map.vh"
module tb_top;
  logic        clk, rst, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0]  pstrb;
  logic [15:0] raw;
  logic [5:0]  exp_int;
  logic [16:0] dec;
  wire         pready, pslverr, step11_enable, step12_enable;
  wire         step11_neg_input_sel, step12_neg_input_sel;
  wire         step11_src_undefined, step12_src_undefined;
  wire  [31:0] prdata;
  wire  [1:0]  step11_gain_sel, step12_gain_sel;
  wire  [1:0]  step11_neg_route, step12_neg_route;
  wire  [3:0]  step11_pos_input_sel, step12_pos_input_sel;
  wire  [2:0]  step11_gain_factor, step12_gain_factor;
  wire  [7:0]  step11_ext_pos_sel, step12_ext_pos_sel;
  wire  [5:0]  step11_int_src_sel, step12_int_src_sel;
  int          error_cnt = 0, checks = 0, cyc = 0;
  logic [47:0] rows [4];
  masc_step_config u_masc_step_config (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .pslverr, .prdata, .step11_enable,
    .step11_gain_sel, .step11_neg_input_sel, .step11_pos_input_sel,
    .step11_gain_factor, .step11_neg_route, .step11_ext_pos_sel,
    .step11_int_src_sel, .step11_src_undefined, .step12_enable,
    .step12_gain_sel, .step12_neg_input_sel, .step12_pos_input_sel,
    .step12_gain_factor, .step12_neg_route, .step12_ext_pos_sel,
    .step12_int_src_sel, .step12_src_undefined);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Edge first, so a new request never lands on the last one's release
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [15:0] d, input logic [3:0] s);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, 16'h0000, d, s};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Table rows: address, strobes, write data, expected readback
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = 0;
    rst = 1'b1;
    rows[0] = {`MASC_STEP11_ADDR, 4'h3, 16'hFFFF, 16'hE01F};
    rows[1] = {`MASC_STEP11_ADDR, 4'h1, 16'h4018, 16'hE018};
    rows[2] = {`MASC_STEP12_ADDR, 4'h3, 16'h2005, 16'h2005};
    rows[3] = {`MASC_STEP12_ADDR, 4'h2, 16'h8013, 16'h8005};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `MASC_STEP11_ADDR, 16'h0000, 4'h0);
    chk(rd, 32'h0000_000B);
    chk(err, 1'b0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, rows[i][47:36], rows[i][31:16], rows[i][35:32]);
      apb(1'b0, rows[i][47:36], 16'h0000, 4'h0);
      chk(rd, {16'h0000, rows[i][15:0]});
      if (rows[i][47:36] == `MASC_STEP11_ADDR)
        raw = {step11_enable, step11_gain_sel, 8'h00, step11_neg_input_sel,
               step11_pos_input_sel};
      else
        raw = {step12_enable, step12_gain_sel, 8'h00, step12_neg_input_sel,
               step12_pos_input_sel};
      chk(raw, rows[i][15:0]);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `MASC_STEP12_ADDR, 16'(i << 13), 4'h3);
      @(posedge clk);
      #1 chk(step12_gain_factor, i == 0 ? 1 : i == 1 ? 2 : 4);
    end
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, `MASC_STEP11_ADDR, 16'(i + 16), 4'h3);
      @(posedge clk);
      #1 chk(step11_neg_route, i > 7 ? 2 : 1);
      chk(step11_ext_pos_sel, i > 7 ? 0 : 1 << i);
      exp_int = i == 12 ? 6'h08 : i == 14 ? 6'h10 : i == 15 ? 6'h20 : 6'h00;
      if (i >= 8 && i <= 10)
        exp_int = 6'(1 << (i - 8));
      chk(step11_int_src_sel, exp_int);
      chk(step11_src_undefined, i == 11 || i == 13);
    end
    apb(1'b1, 12'h274, 16'hFFFF, 4'h3);
    chk(err, 1'b1);
    apb(1'b0, `MASC_STEP12_ADDR, 16'h0000, 4'h0);
    chk(rd, 32'h0000_6000);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `MASC_STEP12_ADDR, 16'h0000, 4'h0);
    chk(rd, 32'h0000_000C);
    dec = {step12_neg_route, step12_ext_pos_sel, step12_int_src_sel,
           step12_src_undefined};
    chk(dec, {2'h2, 8'h00, 6'h08, 1'b0});
    print_verdict();
  end
endmodule // tb_top
